/* pue_defs.vh */
// constants for the uncorrectable error control block
`ifndef PUE_DEFS_VH
`define PUE_DEFS_VH
// register byte offsets
`define PUE_OFF_UNCOR_STS 12'h104
`define PUE_OFF_UNCOR_MASK 12'h108
`define PUE_OFF_UNCOR_SEV 12'h10c
`define PUE_OFF_COR_STS 12'h110
`define PUE_OFF_IRQ_STS 12'h140
`define PUE_OFF_IRQ_CLR 12'h144
`define PUE_OFF_IRQ_EN 12'h148
// implemented uncorrectable bits: 20,18..12,4
`define PUE_UNCOR_IMPL 32'h0017_f010
// implemented correctable bits: 12,8,7,6,0
`define PUE_COR_IMPL 32'h0000_11c1
// reset values
`define PUE_MASK_RST 32'h0000_0000
`define PUE_SEV_RST 32'h0006_2011
`define PUE_STS_RST 32'h0000_0000
`define PUE_IRQ_EN_RST 3'h0
// field positions
`define PUE_BIT_DLP 4
`define PUE_BIT_UNEXP_CPL 16
`define PUE_IRQ_FATAL 0
`define PUE_IRQ_NONFATAL 1
`define PUE_IRQ_MASKED 2
`define PUE_IRQ_W 3
// sequence number width
`define PUE_SEQ_W 12
`endif

/* pue_seq_check.v */
// checks received ack or nak sequence numbers against the replay window
`timescale 1ns/10ps
`include "pue_defs.vh"
module pue_seq_check #(
  parameter SEQ_W = `PUE_SEQ_W
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // received ack or nak
  input wire ack_valid,
  input wire [SEQ_W-1:0] ack_seq,
  // transmit side state
  input wire [SEQ_W-1:0] next_tx_seq,
  input wire [SEQ_W-1:0] last_acked_seq,
  // one-cycle error pulse
  output reg dlp_err
);
  wire [SEQ_W-1:0] dist_ack;
  wire [SEQ_W-1:0] dist_next;
  // distances from the last acked number, modulo the sequence space
  assign dist_ack = ack_seq - last_acked_seq;
  assign dist_next = next_tx_seq - last_acked_seq;
  // zero distance is the last acked tlp, below dist_next is outstanding
  always @(posedge clk)
  begin
    if (rst)
      dlp_err <= 1'b0;
    else
      dlp_err <= ack_valid && (dist_ack >= dist_next); // [RULE1]
  end
endmodule // pue_seq_check

/* pue_msg_gen.v */
// queues fatal and nonfatal error messages toward the root complex
`timescale 1ns/10ps
module pue_msg_gen (
  // clock and reset
  input wire clk,
  input wire rst,
  // requests from newly detected unmasked errors
  input wire req_fatal,
  input wire req_nonfatal,
  // message handshake
  output wire msg_valid,
  output wire msg_fatal,
  input wire msg_ready
);
  reg pend_fatal;
  reg pend_nonfatal;
  wire send;
  // fatal goes out first when both wait
  assign msg_valid = pend_fatal | pend_nonfatal;
  assign msg_fatal = pend_fatal;
  assign send = msg_valid & msg_ready;
  // a new request wins over the clear of the same class
  always @(posedge clk)
  begin
    if (rst)
    begin
      pend_fatal <= 1'b0;
      pend_nonfatal <= 1'b0;
    end
    else
    begin
      pend_fatal <= req_fatal | (pend_fatal & ~send);
      pend_nonfatal <= req_nonfatal | (pend_nonfatal & ~(send & ~pend_fatal));
    end
  end
endmodule // pue_msg_gen

/* pue_top.v */
// uncorrectable error status, mask and severity registers with reporting
// Operation
// [RULE1] ack or nak naming neither outstanding nor last acked tlp sets status bit 4
// [RULE2] protocol error status reads 1 once seen, cleared only by writing 1
// [RULE3] training error status bit 0 is not implemented, reads 0
// [RULE4] a masked error sends no error message to the root complex
// [RULE5] masked errors still set their status bit
// [RULE6] one read-write mask bit per implemented status bit, 1 masks
// [RULE7] ecrc and training mask bits and reserved bits read zero
// [RULE8] mask bits default to 0 so every error is reported
// [RULE9] severity 1 reports fatal, 0 reports nonfatal
// [RULE10] severity resets fatal for malformed, overflow, flow control, protocol errors
// [RULE11] ecrc and training severity bits read only zero
// [RULE12] mask and severity keep values through reset, set only at power-up
// [RULE13] protocol error status is sticky across ordinary reset
// [RULE14] unmatched completion sets status bit 16, loads header log if first
// [RULE15] each unmasked error emits one fatal or nonfatal message per severity; same-class errors in one cycle or while one is pending share a message
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`include "pue_defs.vh"
module pue_top #(
  parameter ADDR_W = 12,
  parameter SEQ_W = `PUE_SEQ_W
) (
  // clock and resets
  input wire clk,
  input wire rst,
  input wire por,
  // register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // error events from the port logic, one-cycle pulses
  input wire [31:0] uncor_evt,
  input wire [31:0] cor_evt,
  input wire cpl_unmatched,
  // ack or nak sequence check inputs
  input wire ack_valid,
  input wire [SEQ_W-1:0] ack_seq,
  input wire [SEQ_W-1:0] next_tx_seq,
  input wire [SEQ_W-1:0] last_acked_seq,
  // header log load strobe
  output reg hdr_log_load,
  // error message toward the root complex
  output wire msg_valid,
  output wire msg_fatal,
  input wire msg_ready,
  // interrupt
  output wire irq
);
  // sticky state, touched only by power-up reset
  reg [31:0] uncor_sts;
  reg [31:0] uncor_mask;
  reg [31:0] uncor_sev;
  reg [31:0] cor_sts;
  // ordinary state
  reg [`PUE_IRQ_W-1:0] irq_sts;
  reg [`PUE_IRQ_W-1:0] irq_en;
  // decode and event wires
  wire run_rst;
  wire hit_uncor_sts;
  wire hit_mask;
  wire hit_sev;
  wire hit_cor_sts;
  wire hit_irq_sts;
  wire hit_irq_clr;
  wire hit_irq_en;
  wire dlp_err;
  wire [31:0] dlp_vec;
  wire [31:0] cpl_vec;
  wire [31:0] new_err;
  wire [31:0] unmasked;
  wire [31:0] masked_hit;
  wire [31:0] uncor_clr;
  wire [31:0] cor_clr;
  wire any_fatal;
  wire any_nonfatal;
  wire any_masked;
  wire [`PUE_IRQ_W-1:0] irq_evt;
  wire [`PUE_IRQ_W-1:0] irq_clr;
  reg [31:0] next_rdata;

  // power-up also clears everything an ordinary reset does
  assign run_rst = rst | por;

  // address decode
  assign hit_uncor_sts = (reg_addr == `PUE_OFF_UNCOR_STS);
  assign hit_mask = (reg_addr == `PUE_OFF_UNCOR_MASK);
  assign hit_sev = (reg_addr == `PUE_OFF_UNCOR_SEV);
  assign hit_cor_sts = (reg_addr == `PUE_OFF_COR_STS);
  assign hit_irq_sts = (reg_addr == `PUE_OFF_IRQ_STS);
  assign hit_irq_clr = (reg_addr == `PUE_OFF_IRQ_CLR);
  assign hit_irq_en = (reg_addr == `PUE_OFF_IRQ_EN);

  // sequence number checker for data link protocol errors
  pue_seq_check #(
    .SEQ_W(SEQ_W)
  ) u_seq (
    .clk(clk),
    .rst(run_rst),
    .ack_valid(ack_valid),
    .ack_seq(ack_seq),
    .next_tx_seq(next_tx_seq),
    .last_acked_seq(last_acked_seq),
    .dlp_err(dlp_err)
  );

  // gather all error sources into one vector of implemented bits
  assign dlp_vec = {{(31-`PUE_BIT_DLP){1'b0}}, dlp_err, {`PUE_BIT_DLP{1'b0}}}; // [RULE1]
  assign cpl_vec = {{(31-`PUE_BIT_UNEXP_CPL){1'b0}}, cpl_unmatched,
                    {`PUE_BIT_UNEXP_CPL{1'b0}}}; // [RULE14]
  assign new_err = (uncor_evt | dlp_vec | cpl_vec) & `PUE_UNCOR_IMPL; // [RULE3]

  // mask splits detected errors into reported and silent ones
  assign unmasked = new_err & ~uncor_mask; // [RULE4]
  assign masked_hit = new_err & uncor_mask;

  // severity picks the message type for each reported error
  assign any_fatal = |(unmasked & uncor_sev); // [RULE9]
  assign any_nonfatal = |(unmasked & ~uncor_sev); // [RULE9]
  assign any_masked = |masked_hit;

  // write-one-to-clear masks
  assign uncor_clr = (reg_wr && hit_uncor_sts) ? reg_wdata : 32'h0000_0000; // [RULE2]
  assign cor_clr = (reg_wr && hit_cor_sts) ? reg_wdata : 32'h0000_0000;

  // uncorrectable status: set wins over clear, survives ordinary reset
  always @(posedge clk)
  begin
    if (por)
      uncor_sts <= `PUE_STS_RST; // [RULE13]
    else
      uncor_sts <= ((uncor_sts & ~uncor_clr) | new_err) & `PUE_UNCOR_IMPL; // [RULE2] [RULE5]
  end

  // header log loads when the first uncorrectable error arrives
  always @(posedge clk)
  begin
    if (run_rst)
      hdr_log_load <= 1'b0;
    else
      hdr_log_load <= (uncor_sts == 32'h0000_0000) && (|new_err); // [RULE14]
  end

  // mask register, only implemented bits hold a value
  always @(posedge clk)
  begin
    if (por)
      uncor_mask <= `PUE_MASK_RST; // [RULE8] [RULE12]
    else if (reg_wr && hit_mask)
      uncor_mask <= reg_wdata & `PUE_UNCOR_IMPL; // [RULE6] [RULE7]
  end

  // severity register, only implemented bits hold a value
  always @(posedge clk)
  begin
    if (por)
      uncor_sev <= `PUE_SEV_RST & `PUE_UNCOR_IMPL; // [RULE10] [RULE11] [RULE12]
    else if (reg_wr && hit_sev)
      uncor_sev <= reg_wdata & `PUE_UNCOR_IMPL; // [RULE11]
  end

  // correctable status: sticky, write one to clear, set wins
  always @(posedge clk)
  begin
    if (por)
      cor_sts <= `PUE_STS_RST;
    else
      cor_sts <= ((cor_sts & ~cor_clr) | cor_evt) & `PUE_COR_IMPL;
  end

  // message generator, one message per class per detection cycle
  pue_msg_gen u_msg (
    .clk(clk),
    .rst(run_rst),
    .req_fatal(any_fatal), // [RULE15]
    .req_nonfatal(any_nonfatal), // [RULE15]
    .msg_valid(msg_valid),
    .msg_fatal(msg_fatal),
    .msg_ready(msg_ready)
  );

  // interrupt events: unmasked fatal detected, unmasked nonfatal detected, masked error logged
  assign irq_evt = {any_masked, any_nonfatal, any_fatal};
  assign irq_clr = (reg_wr && hit_irq_clr) ? reg_wdata[`PUE_IRQ_W-1:0] : `PUE_IRQ_EN_RST;

  // interrupt status: sticky until cleared, set wins
  always @(posedge clk)
  begin
    if (run_rst)
      irq_sts <= `PUE_IRQ_EN_RST;
    else
      irq_sts <= (irq_sts & ~irq_clr) | irq_evt;
  end

  // interrupt enable
  always @(posedge clk)
  begin
    if (run_rst)
      irq_en <= `PUE_IRQ_EN_RST;
    else if (reg_wr && hit_irq_en)
      irq_en <= reg_wdata[`PUE_IRQ_W-1:0];
  end

  // level interrupt while an enabled status bit is set
  assign irq = |(irq_sts & irq_en);

  // read mux, unmapped and write-only offsets read zero
  always @*
  begin
    next_rdata = 32'h0000_0000;
    if (hit_uncor_sts)
      next_rdata = uncor_sts; // [RULE3]
    else if (hit_mask)
      next_rdata = uncor_mask; // [RULE7]
    else if (hit_sev)
      next_rdata = uncor_sev; // [RULE11]
    else if (hit_cor_sts)
      next_rdata = cor_sts;
    else if (hit_irq_sts)
      next_rdata = {{(32-`PUE_IRQ_W){1'b0}}, irq_sts};
    else if (hit_irq_en)
      next_rdata = {{(32-`PUE_IRQ_W){1'b0}}, irq_en};
  end

  // read data stand only in the cycle after the read strobe
  always @(posedge clk)
  begin
    if (run_rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h0000_0000;
  end
endmodule // pue_top

/* pue_chk_assertions.sv */
// assertion checker for the uncorrectable error control block
`timescale 1ns/10ps
module pue_chk #(parameter ADDR_W = 12, parameter SEQ_W = 12) (
  // clock and resets
  input wire clk,
  input wire rst,
  input wire por,
  // register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // events and reporting
  input wire [31:0] uncor_evt,
  input wire cpl_unmatched,
  input wire ack_valid,
  input wire [SEQ_W-1:0] ack_seq,
  input wire [SEQ_W-1:0] next_tx_seq,
  input wire [SEQ_W-1:0] last_acked_seq,
  input wire hdr_log_load,
  input wire msg_valid,
  input wire msg_fatal,
  input wire msg_ready
);
  reg [31:0] msk;
  wire [SEQ_W-1:0] d_ack = ack_seq - last_acked_seq;
  wire [SEQ_W-1:0] d_out = next_tx_seq - last_acked_seq;
  // shadow of the mask register, cleared only at power-up
  always @(posedge clk)
  begin
    if (por) msk <= 32'h0;
    else if (reg_wr && reg_addr == 12'h108) msk <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || por);
  mask_read_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 12'h108
    |-> (reg_rdata & 32'hffe80fef) == 32'h0) else $error("mask unimplemented bit set");
  sev_read_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 12'h10c
    |-> (reg_rdata & 32'hffe80fef) == 32'h0) else $error("severity unimplemented bit set");
  sts_bit0_a: assert property ($past(reg_rd) && $past(reg_addr) == 12'h104
    |-> !reg_rdata[0]) else $error("training status bit set");
  evt_msg_a: assert property (uncor_evt[18] && !msk[18] && !msg_valid |=> msg_valid)
    else $error("unmasked error sent no message");
  masked_quiet_a: assert property (uncor_evt == 32'h40000 && msk[18] && !msg_valid
    && !cpl_unmatched && !ack_valid && !$past(ack_valid) |=> !msg_valid)
    else $error("masked error sent a message");
  cpl_msg_a: assert property (cpl_unmatched && !msk[16] && !msg_valid |=> msg_valid)
    else $error("unmatched completion sent no message");
  dlp_seq_a: assert property (ack_valid && d_ack >= d_out && !msk[4] && !msg_valid
    |-> ##[1:2] msg_valid) else $error("bad ack sequence not reported");
  msg_hold_a: assert property (msg_valid && !msg_ready |=> msg_valid)
    else $error("message dropped before accept");
  hdr_pulse_a: assert property (hdr_log_load |=> !hdr_log_load)
    else $error("header log load repeated");
  cover property (msg_valid && msg_ready && msg_fatal);
  cover property (msg_valid && msg_ready && !msg_fatal);
  cover property (hdr_log_load);
endmodule // pue_chk

/* pue_rc_model.sv */
// root complex model that accepts error messages promptly or slowly
`timescale 1ns/10ps
module pue_rc (
  // clock, reset and pace
  input wire clk,
  input wire rst,
  input wire slow,
  // message handshake and counts
  input wire msg_valid,
  input wire msg_fatal,
  output reg msg_ready,
  output integer n_fat,
  output integer n_nf
);
  reg [1:0] cnt;
  // ready every cycle, or one cycle in four when slow; count accepted messages
  initial
  begin
    n_fat = 0;
    n_nf = 0;
    cnt = 2'h0;
    msg_ready = 1'b0;
  end
  always @(posedge clk)
  begin
    cnt <= rst ? 2'h0 : cnt + 2'h1;
    msg_ready <= !slow || cnt == 2'h3;
    if (msg_valid && msg_ready && msg_fatal) n_fat <= n_fat + 1;
    if (msg_valid && msg_ready && !msg_fatal) n_nf <= n_nf + 1;
  end
endmodule // pue_rc

/* testbench.sv */
// self-checking bench for the uncorrectable error control block
`timescale 1ns/10ps
`include "pue_defs.vh"
module testbench;
  localparam [11:0] MK = `PUE_OFF_UNCOR_MASK;
  localparam [11:0] SV = `PUE_OFF_UNCOR_SEV;
  localparam [11:0] ST = `PUE_OFF_UNCOR_STS;
  localparam [31:0] IMP = `PUE_UNCOR_IMPL;
  reg clk, rst, por, reg_wr, reg_rd, cpl_unmatched, ack_valid, slow;
  reg [11:0] reg_addr, ack_seq;
  reg [31:0] reg_wdata, uncor_evt, m, s, sts;
  wire [31:0] reg_rdata;
  wire msg_valid, msg_fatal, msg_ready, irq;
  integer n_fat, n_nf, ef, en, miscompares, n_tests, cyc, i, n_hdr, eh;
  wire hdr;
  integer bits [0:8];
  pue_top dut (.clk, .rst, .por, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .uncor_evt, .cor_evt(32'h0), .cpl_unmatched, .ack_valid, .ack_seq,
    .next_tx_seq(12'h014), .last_acked_seq(12'h00a), .hdr_log_load(hdr),
    .msg_valid, .msg_fatal, .msg_ready, .irq);
  pue_rc rc (.clk, .rst, .slow, .msg_valid, .msg_fatal, .msg_ready, .n_fat, .n_nf);
  // clock and hang guard
  initial
  begin
    clk = 0;
    cyc = 0;
    forever #4 clk = ~clk;
  end
  // count header log load pulses seen from the design
  always @(posedge clk)
  begin
    if (hdr) n_hdr <= n_hdr + 1;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  // compare and bus tasks
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task wr(input [11:0] a, input [31:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [11:0] a, input [31:0] e);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  end
  endtask
  // one error event, then the model of logging and reporting
  task ev(input integer b);
  begin
    @(posedge clk);
    if (b == 4) ack_valid <= 1'b1;
    else if (b == 16) cpl_unmatched <= 1'b1;
    else uncor_evt <= 32'h1 << b;
    @(posedge clk);
    ack_valid <= 1'b0;
    cpl_unmatched <= 1'b0;
    uncor_evt <= 32'h0;
    repeat (12) @(posedge clk);
    if (sts == 32'h0) eh = eh + 1;
    sts = sts | (32'h1 << b);
    if (!m[b] && s[b]) ef = ef + 1;
    if (!m[b] && !s[b]) en = en + 1;
  end
  endtask
  task print_verdict;
  begin
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end
  endtask
  // main sequence
  initial
  begin
    i = $urandom(41);
    {miscompares, n_tests, ef, en} = 128'h0;
    n_hdr = 0;
    eh = 0;
    {sts, m, s} = {64'h0, 32'h00062011 & IMP};
    {rst, por, reg_wr, reg_rd, cpl_unmatched, ack_valid, slow} = 7'h60;
    {reg_addr, reg_wdata, uncor_evt, ack_seq} = {76'h0, 12'h014};
    bits = '{20, 18, 17, 16, 15, 14, 13, 12, 4};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    rd(MK, 32'h0);
    rd(SV, s);
    rd(ST, 32'h0);
    rd(12'h1f0, 32'h0);
    wr(MK, 32'hffffffff);
    rd(MK, IMP);
    wr(SV, 32'hffffffff);
    rd(SV, IMP);
    wr(ST, 32'hffffffff);
    {m, s} = {IMP, IMP};
    ev(18);
    rd(ST, sts);
    chk("fatal", n_fat, ef);
    @(posedge clk);
    ack_seq <= 12'h00a;
    ack_valid <= 1'b1;
    @(posedge clk);
    ack_seq <= 12'h013;
    @(posedge clk);
    ack_valid <= 1'b0;
    ack_seq <= 12'h014;
    repeat (4) @(posedge clk);
    rd(ST, sts);
    for (i = 0; i < 9; i = i + 1)
    begin
      slow <= i[0];
      m = $urandom & IMP;
      s = $urandom & IMP;
      wr(MK, m);
      wr(SV, s);
      ev(bits[i]);
      rd(ST, sts);
      chk("fatal", n_fat, ef);
      chk("nonfatal", n_nf, en);
      sts = sts & ~(32'h1 << bits[i]);
      wr(ST, 32'h1 << bits[i]);
      rd(ST, sts);
    end
    ev(4);
    wr(ST, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(MK, m);
    rd(SV, s);
    rd(ST, sts);
    m = 32'h0;
    wr(MK, m);
    wr(`PUE_OFF_IRQ_EN, 32'h7);
    ev(12);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("hdrload", n_hdr, eh);
    wr(`PUE_OFF_IRQ_EN, 32'h0);
    #1 chk("irq", {31'h0, irq}, 32'h0);
    wr(`PUE_OFF_IRQ_EN, 32'h7);
    #1 chk("irq", {31'h0, irq}, 32'h1);
    wr(`PUE_OFF_IRQ_CLR, 32'h7);
    #1 chk("irq", {31'h0, irq}, 32'h0);
    por <= 1'b1;
    repeat (2) @(posedge clk);
    por <= 1'b0;
    rd(MK, 32'h0);
    rd(ST, 32'h0);
    print_verdict;
  end
endmodule // testbench
bind pue_top pue_chk #(.ADDR_W(ADDR_W), .SEQ_W(SEQ_W)) u_chk (.clk, .rst, .por, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .uncor_evt, .cpl_unmatched, .ack_valid,
  .ack_seq, .next_tx_seq, .last_acked_seq, .hdr_log_load, .msg_valid, .msg_fatal,
  .msg_ready);
